/* File: design/prf_consts.vh */
// Constants for the program fetch and branch block
`ifndef PRF_CONSTS_VH
`define PRF_CONSTS_VH
// ==========================================================
// Address map
`define PRF_PC_W 10
`define PRF_OPND_W 11
`define PRF_WORD_W 16
`define PRF_RESET_VEC 10'h000
`define PRF_VEC_SERIAL 10'h001
`define PRF_VEC_TIMER 10'h002
`define PRF_VEC_EXT 10'h003
`define PRF_SMALL_WORDS 11'h300
`define PRF_SMALL_LIMIT 10'h300
`define PRF_LARGE_WORDS 11'h400
`define PRF_FILL_WORD 16'hFFFF
// ==========================================================
// Operation codes from the sequencer
`define PRF_OP_STEP 3'h0
`define PRF_OP_JUMP 3'h1
`define PRF_OP_CALL 3'h2
`define PRF_OP_JUMP_AR 3'h3
`define PRF_OP_CALL_AR 3'h4
`define PRF_OP_TABLE 3'h5
`define PRF_OP_RETURN 3'h6
`define PRF_OP_HOLD 3'h7
// Interrupt source codes
`define PRF_IRQ_SERIAL 2'h1
`define PRF_IRQ_TIMER 2'h2
`define PRF_IRQ_EXT 2'h3
`endif

/* File: design/prf_rom.v */
// Read-only program store with synchronous read
`timescale 1ns/1ps
module prf_rom #(
  parameter LARGE = 1
) (
  // Clock
  input wire core_clk,
  input wire ce,
  // Read port
  input wire [9:0] addr,
  output reg [15:0] data_q
);
`include "prf_consts.vh"
  // ========================================================
  // Storage: no write port exists, contents are fixed
  reg [15:0] mem [0:1023];
  integer i;
  initial begin
    for (i = 0; i < 1024; i = i + 1) begin
      mem[i] = `PRF_FILL_WORD;
    end
  end

  always @(posedge core_clk) begin
    if (ce) begin
      // Small part decodes 300H and above as all ones
      if (!LARGE && addr >= `PRF_SMALL_LIMIT) begin
        data_q <= `PRF_FILL_WORD;
      end else begin
        data_q <= mem[addr];
      end
    end
  end
endmodule // prf_rom

/* File: design/prf_fetch.v */
// Program counter, next-address selection and table read sequencing
// ==========================================================
// Notes on behaviour
// - Small build holds 768 words, addresses 000H to 2FFH.
// - Large build holds 1024 words, addresses 000H to 3FFH.
// - Fetch starts at 000H after reset, then steps one word.
// - Interrupt vectors: serial 001H, timer 002H, external pin 003H.
// - One 16-bit word per instruction, one fetch each.
// - Direct jump loads counter from 11-bit operand, top bit zero.
// - Direct call takes target from 11-bit operand, top bit zero.
// - Indirect jump copies address register into counter.
// - Indirect call redirects fetch to address register.
// - Table read puts word at address register into data buffer.
// - Table read takes two instruction cycles, others take one.
// - Table read borrows one stack level, released when done.
// - Program words cannot be altered by any instruction.
// - Counter is 10-bit, cleared by reset, incremented per instruction.
// - Small build returns FFFFH at 300H and above.
// - Call, table read first cycle, interrupt push counter plus one.
`timescale 1ns/1ps
module prf_fetch #(
  parameter LARGE = 1
) (
  // Clock and reset
  input wire core_clk,
  input wire rst,
  input wire ce,
  // Sequencer request, one per instruction cycle
  input wire op_valid,
  input wire [2:0] op_code,
  input wire [10:0] op_operand,
  input wire irq_accept,
  input wire [1:0] irq_source,
  // Address register
  input wire [9:0] address_register,
  // Address stack
  input wire [9:0] stack_top,
  output wire stack_push,
  output wire stack_pop,
  output reg [9:0] stack_push_data_q,
  // Fetched word
  output wire [15:0] instr_word,
  // Data buffer
  output reg [15:0] data_buffer_q,
  output reg data_buffer_we_q,
  // Status
  output wire busy,
  output wire [9:0] program_counter
);
`include "prf_consts.vh"
  // ========================================================
  // Table read state
  localparam ST_RUN = 1'b0;
  localparam ST_TABLE = 1'b1;

  reg state_q;
  reg state_d;
  reg [9:0] pc_q;
  reg [9:0] pc_d;
  reg [9:0] rom_addr;
  reg push_d;
  reg pop_d;
  reg [9:0] push_data_d;
  reg tbl_capture_q;
  wire tbl_start;
  wire [15:0] rom_data;

  function [9:0] operand_target;
    input [10:0] opnd;
    begin
      // Top operand bit must be zero; it is ignored here
      operand_target = opnd[9:0];
    end
  endfunction

  function [9:0] irq_vector;
    input [1:0] src;
    begin
      case (src)
        `PRF_IRQ_SERIAL: irq_vector = `PRF_VEC_SERIAL;
        `PRF_IRQ_TIMER: irq_vector = `PRF_VEC_TIMER;
        `PRF_IRQ_EXT: irq_vector = `PRF_VEC_EXT;
        default: irq_vector = `PRF_RESET_VEC;
      endcase
    end
  endfunction

  function [9:0] step_addr;
    input [9:0] addr;
    begin
      // Wraps from 3FFH to 000H like the 10-bit counter it models
      step_addr = addr + 10'h001;
    end
  endfunction

  function table_start;
    input st;
    input valid;
    input irq;
    input [2:0] code;
    begin
      // An accepted interrupt outranks a table read in the same cycle
      table_start = (st == ST_RUN) && valid && !irq &&
        (code == `PRF_OP_TABLE);
    end
  endfunction

  // ========================================================
  // Fetch address: a table read lends the ROM port for one cycle
  assign tbl_start = table_start(state_q, op_valid, irq_accept, op_code);

  always @* begin
    rom_addr = pc_q;
    if (tbl_start) begin
      rom_addr = address_register;
    end
  end

  // ========================================================
  // Next address
  always @* begin
    state_d = state_q;
    pc_d = pc_q;
    push_d = 1'b0;
    pop_d = 1'b0;
    push_data_d = step_addr(pc_q);
    case (state_q)
      ST_RUN: begin
        if (irq_accept) begin
          pc_d = irq_vector(irq_source);
          push_d = 1'b1;
        end else if (op_valid) begin
          case (op_code)
            `PRF_OP_STEP: pc_d = step_addr(pc_q);
            `PRF_OP_JUMP: pc_d = operand_target(op_operand);
            `PRF_OP_CALL: begin
              pc_d = operand_target(op_operand);
              push_d = 1'b1;
            end
            `PRF_OP_JUMP_AR: pc_d = address_register;
            `PRF_OP_CALL_AR: begin
              pc_d = address_register;
              push_d = 1'b1;
            end
            `PRF_OP_TABLE: begin
              // First cycle: borrow a stack level, ROM reads the table
              push_d = 1'b1;
              state_d = ST_TABLE;
            end
            `PRF_OP_RETURN: begin
              pc_d = stack_top;
              pop_d = 1'b1;
            end
            default: pc_d = pc_q;
          endcase
        end
      end
      ST_TABLE: begin
        // Second cycle: restore return address, free the level
        pc_d = stack_top;
        pop_d = 1'b1;
        state_d = ST_RUN;
      end
      default: state_d = ST_RUN;
    endcase
  end

  // No strobes reach the stack while reset holds the counter
  assign stack_push = ce & push_d & ~rst;
  assign stack_pop = ce & pop_d & ~rst;
  assign busy = (state_q == ST_TABLE);
  assign program_counter = pc_q;

  // ========================================================
  // Counter and sequencing state
  always @(posedge core_clk) begin
    if (rst) begin
      pc_q <= `PRF_RESET_VEC;
      state_q <= ST_RUN;
      tbl_capture_q <= 1'b0;
    end else if (ce) begin
      pc_q <= pc_d;
      state_q <= state_d;
      tbl_capture_q <= tbl_start;
    end
  end

  // ========================================================
  // Return address towards the stack
  always @(posedge core_clk) begin
    if (rst) begin
      stack_push_data_q <= 10'h000;
    end else if (ce) begin
      stack_push_data_q <= push_data_d;
    end
  end

  // ========================================================
  // Data buffer load on the second table read cycle
  always @(posedge core_clk) begin
    if (rst) begin
      data_buffer_q <= 16'h0000;
      data_buffer_we_q <= 1'b0;
    end else if (ce) begin
      data_buffer_we_q <= 1'b0;
      // ROM word addressed in the first cycle arrives now
      if (tbl_capture_q) begin
        data_buffer_q <= rom_data;
        data_buffer_we_q <= 1'b1;
      end
    end
  end

  prf_rom #(
    .LARGE(LARGE)
  ) u_rom (
    .core_clk(core_clk),
    .ce(ce),
    .addr(rom_addr),
    .data_q(rom_data)
  );

  // Word fetched for the previous address, from the ROM register
  assign instr_word = rom_data;
endmodule // prf_fetch

/* File: test/prf_fetch_properties.sv */
// Port assertions for the program fetch block
`timescale 1ns/1ps
`include "prf_consts.vh"
module prf_props (
  // Inputs
  input wire core_clk, input wire rst, input wire ce,
  input wire op_valid, input wire [2:0] op_code,
  input wire [10:0] op_operand, input wire irq_accept,
  input wire [1:0] irq_source, input wire [9:0] address_register,
  input wire [9:0] stack_top,
  // Outputs
  input wire stack_push, input wire stack_pop,
  input wire [9:0] stack_push_data_q, input wire [15:0] instr_word,
  input wire [15:0] data_buffer_q, input wire data_buffer_we_q,
  input wire busy, input wire [9:0] program_counter
);
  wire tk = ce && op_valid && !irq_accept && !busy;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_rst; $fell(rst) |-> program_counter == 10'h000; endproperty
  a_rst: assert property (p_rst) else $error("pc not clear");
  property p_step; tk && op_code == `PRF_OP_STEP
    |=> program_counter == $past(program_counter) + 10'h001; endproperty
  a_step: assert property (p_step) else $error("bad step");
  property p_jmp; tk && op_code == `PRF_OP_JUMP
    |=> program_counter == $past(op_operand[9:0]); endproperty
  a_jmp: assert property (p_jmp) else $error("bad jump");
  property p_jar; tk && op_code == `PRF_OP_JUMP_AR
    |=> program_counter == $past(address_register); endproperty
  a_jar: assert property (p_jar) else $error("bad reg jump");
  property p_call; tk && op_code == `PRF_OP_CALL |-> stack_push ##1
    program_counter == $past(op_operand[9:0]) &&
    stack_push_data_q == $past(program_counter) + 10'h001; endproperty
  a_call: assert property (p_call) else $error("bad call");
  property p_irq; ce && irq_accept && irq_source != 2'h0 && !busy
    |-> stack_push ##1 program_counter == {8'h00, $past(irq_source)};
  endproperty
  a_irq: assert property (p_irq) else $error("bad vector");
  property p_tbl; tk && op_code == `PRF_OP_TABLE
    |-> stack_push ##1 busy && stack_pop ##1 data_buffer_we_q; endproperty
  a_tbl: assert property (p_tbl) else $error("bad table");
  property p_one; busy && ce |=> !busy; endproperty
  a_one: assert property (p_one) else $error("busy too long");
  property p_ret; busy && ce |=> program_counter == $past(stack_top);
  endproperty
  a_ret: assert property (p_ret) else $error("no restore");
  c_tbl: cover property (tk && op_code == `PRF_OP_TABLE);
  c_irq: cover property (ce && irq_accept);
  c_call: cover property (tk && op_code == `PRF_OP_CALL);
endmodule // prf_props
bind prf_fetch prf_props u_chk (.core_clk, .rst, .ce, .op_valid,
  .op_code, .op_operand, .irq_accept, .irq_source, .address_register,
  .stack_top, .stack_push, .stack_pop, .stack_push_data_q, .instr_word,
  .data_buffer_q, .data_buffer_we_q, .busy, .program_counter);

/* File: test/prf_stack_model.sv */
// One-level address stack model for the fetch block
`timescale 1ns/1ps
module prf_stack_model (
  input wire core_clk, input wire rst, input wire ce,
  input wire stack_push, input wire stack_pop,
  input wire [9:0] stack_push_data_q, output wire [9:0] stack_top
);
  logic push_q;
  logic [9:0] top_q;
  // Push data lands a cycle after its strobe, so forward it
  assign stack_top = push_q ? stack_push_data_q : top_q;
  always @(posedge core_clk) begin
    if (rst) begin
      push_q <= 1'b0;
      top_q <= 10'h2AA;
    end else if (ce) begin
      push_q <= stack_push;
      // A pop consumes the forwarded value, then the level is released
      if (stack_pop)
        top_q <= ~stack_top; // Released level shows no stale value
      else if (push_q)
        top_q <= stack_push_data_q;
    end
  end
endmodule // prf_stack_model

/* File: test/tb.sv */
// Testbench for the program fetch block
`timescale 1ns/1ps
`include "prf_consts.vh"
module tb;
  logic core_clk, rst, ce, op_valid, irq_accept, stack_push, stack_pop;
  logic data_buffer_we_q, busy;
  logic [2:0] op_code;
  logic [10:0] op_operand;
  logic [1:0] irq_source;
  logic [9:0] address_register, stack_top, stack_push_data_q;
  logic [9:0] program_counter;
  logic [15:0] instr_word, data_buffer_q;
  int miscompares, num_checks;
  prf_fetch #(.LARGE(0)) DUT (.core_clk, .rst, .ce, .op_valid, .op_code,
    .op_operand, .irq_accept, .irq_source, .address_register, .stack_top,
    .stack_push, .stack_pop, .stack_push_data_q, .instr_word,
    .data_buffer_q, .data_buffer_we_q, .busy, .program_counter);
  prf_stack_model u_stk (.core_clk, .rst, .ce, .stack_push, .stack_pop,
    .stack_push_data_q, .stack_top);
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task op(input logic [2:0] c, input logic [10:0] a);
    @(posedge core_clk);
    op_valid <= 1'b1;
    op_code <= c;
    op_operand <= a;
    @(posedge core_clk);
    op_valid <= 1'b0;
    #1;
  endtask
  task t_flow;
    chk("pc", 16'(program_counter), 16'h0000);
    op(`PRF_OP_STEP, 11'h000);
    chk("pc", 16'(program_counter), 16'h0001);
    op(`PRF_OP_JUMP, 11'h2FF);
    chk("pc", 16'(program_counter), 16'h02FF);
    op(`PRF_OP_STEP, 11'h000);
    chk("word", instr_word, 16'h5A3C);
    @(posedge core_clk);
    #1;
    chk("word", instr_word, 16'hFFFF);
  endtask
  task t_calls;
    address_register <= 10'h155;
    op(`PRF_OP_CALL_AR, 11'h000);
    chk("pc", 16'(program_counter), 16'h0155);
    chk("push", 16'(stack_push_data_q), 16'h0301);
    op(`PRF_OP_CALL, 11'h07F);
    chk("pc", 16'(program_counter), 16'h007F);
    chk("push", 16'(stack_push_data_q), 16'h0156);
    address_register <= 10'h3C3;
    op(`PRF_OP_JUMP_AR, 11'h000);
    chk("pc", 16'(program_counter), 16'h03C3);
    op(`PRF_OP_RETURN, 11'h000);
    chk("pc", 16'(program_counter), 16'h0156);
    op(`PRF_OP_HOLD, 11'h000);
    chk("pc", 16'(program_counter), 16'h0156);
    // Clock enable low: the step must not be taken
    ce <= 1'b0;
    op(`PRF_OP_STEP, 11'h000);
    chk("pc", 16'(program_counter), 16'h0156);
    ce <= 1'b1;
  endtask
  task t_irq;
    for (int s = 1; s < 4; s++) begin
      @(posedge core_clk);
      irq_accept <= 1'b1;
      irq_source <= 2'(s);
      @(posedge core_clk);
      irq_accept <= 1'b0;
      #1;
      chk("vec", 16'(program_counter), 16'(s));
    end
  endtask
  task t_table;
    address_register <= 10'h0F0;
    @(posedge core_clk);
    op_valid <= 1'b1;
    op_code <= `PRF_OP_TABLE;
    @(posedge core_clk);
    // Jump and interrupt in the second cycle must both be refused
    op_code <= `PRF_OP_JUMP;
    irq_accept <= 1'b1;
    irq_source <= 2'h3;
    #1;
    chk("busy", 16'(busy), 16'h0001);
    @(posedge core_clk);
    op_valid <= 1'b0;
    irq_accept <= 1'b0;
    #1;
    chk("dbuf", data_buffer_q, 16'hA5C3);
    chk("we", 16'(data_buffer_we_q), 16'h0001);
    chk("pc", 16'(program_counter), 16'h0004);
    @(posedge core_clk);
    #1;
    chk("we", 16'(data_buffer_we_q), 16'h0000);
    chk("dbuf", data_buffer_q, 16'hA5C3);
    chk("pc", 16'(program_counter), 16'h0004);
  endtask
  task t_reset;
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    chk("pc", 16'(program_counter), 16'h0000);
    chk("dbuf", data_buffer_q, 16'h0000);
    op(`PRF_OP_STEP, 11'h000);
    chk("pc", 16'(program_counter), 16'h0001);
  endtask
  initial begin
    {rst, ce, op_valid, irq_accept} = 4'hC;
    {op_code, op_operand, irq_source, address_register} = 26'h0;
    repeat (6) @(posedge core_clk);
    // Distinct words, so fetches and table reads can be told apart
    DUT.u_rom.mem[10'h2FF] <= 16'h5A3C;
    DUT.u_rom.mem[10'h300] <= 16'h1234;
    DUT.u_rom.mem[10'h0F0] <= 16'hA5C3;
    rst <= 1'b0;
    @(posedge core_clk);
    #1;
    t_flow;
    t_calls;
    t_irq;
    t_table;
    t_reset;
    tally_and_finish;
  end
  initial begin
    repeat (2000) @(posedge core_clk);
    miscompares++;
    tally_and_finish;
  end
endmodule // tb
